/* File: eeprom_consts.vh */
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// Register byte offsets on the Wishbone bus.
`define OFS_HW_CONFIG 10'h074
`define OFS_COMMAND 10'h1b4
`define OFS_BYTE 10'h1b8

// Command register fields, and the ready bit of the hardware config register.
`define CMD_BUSY_BIT 31
`define CMD_CODE_HI 30
`define CMD_CODE_LO 28
`define CMD_OVERFLOW_BIT 18
`define CMD_TIMEOUT_BIT 17
`define CMD_LOADED_BIT 16
`define HW_READY_BIT 27

// Command codes.
`define CODE_READ 3'h0
`define CODE_WRITE 3'h3
`define CODE_RELOAD 3'h7

// Reset values.
`define RST_ADDR 16'h0000
`define RST_BYTE 8'h00

// Loader constants.
`define SIGNATURE 8'ha5
`define EE_ADDR_LAST 16'h07ff
`define DEV_WRITE 8'ha0
`define DEV_READ 8'ha1

// Timing.
`define CLK_PERIOD_NS 50
`define QUARTER_NS 2500
`define QUARTER_CYC (`QUARTER_NS / `CLK_PERIOD_NS)
`define WR_TIMEOUT_MS 30
`define ACQ_TIMEOUT_MS 1920
`define WR_TIMEOUT_CYC (`WR_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)
`define ACQ_TIMEOUT_CYC (`ACQ_TIMEOUT_MS * 1000000 / `CLK_PERIOD_NS)

// Bit engine operations.
`define OP_START 2'h0
`define OP_STOP 2'h1
`define OP_WBYTE 2'h2
`define OP_RBYTE 2'h3

`endif

/* File: eeprom_command_status.v */
// Operation
// - Unsupported command code: busy stays clear, timeout flag set, no EEPROM access.
// - Read command fetches the EEPROM byte at the controller address field.
// - Completed read places the fetched byte into the EEPROM byte register.
// - Write command stores the byte register contents at the addressed location.
// - Reload restarts the loader; missing A5h signature at address zero fails it.
// - Reload drops device ready; software polls the ready bit until it returns.
// - Loader reading past the address space end sets read-only overflow bit 18.
// - Overflow flag clears whenever a reload command restarts the loader.
// - Timeout bit 17 set on 30 ms write silence or 1.92 s bus acquisition.
// - Timeout flag resets to zero, cleared only by writing one to it.
// - Loaded bit 16 set when valid EEPROM found and loader finishes normally.
// - Loaded flag cleared by reset and at the start of every reload.
// - Address field bits 15:0 reset to zero, selects the EEPROM location.
// - Byte register holds an eight-bit read/write field, reset to zero.
`timescale 1ns/1ps
`include "eeprom_consts.vh"

module eeprom_command_status #(
    parameter WR_CYCLES = `WR_TIMEOUT_CYC,
    parameter ACQ_CYCLES = `ACQ_TIMEOUT_CYC
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Serial EEPROM link, open drain
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Loader output and device state
    output reg ready_o,
    output reg [15:0] cfg_addr_o,
    output reg [7:0] cfg_data_o,
    output reg cfg_we_o
);

// Limits are kept at full width and sliced to each counter's width where compared.
localparam [31:0] Q_LAST = `QUARTER_CYC - 1;
localparam [31:0] ACQ_LAST = ACQ_CYCLES - 1;
localparam [31:0] WR_LAST = WR_CYCLES - 1;

localparam S_IDLE = 4'h0;
localparam S_START = 4'h1;
localparam S_DEVW = 4'h2;
localparam S_AHI = 4'h3;
localparam S_ALO = 4'h4;
localparam S_WDATA = 4'h5;
localparam S_RSTART = 4'h6;
localparam S_DEVR = 4'h7;
localparam S_RDATA = 4'h8;
localparam S_STOP = 4'h9;
localparam S_FINISH = 4'ha;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers.

reg scl_m, scl_s, sda_m, sda_s;

always @(posedge clk_i) begin
    scl_m <= scl_i;
    scl_s <= scl_m;
    sda_m <= sda_i;
    sda_s <= sda_m;
end

////////////////////////////////////////////////////////////////////////////////
// Bit engine: one START, STOP or nine-bit byte slot per request.

reg eng_go;
reg [1:0] eng_op;
reg [8:0] eng_tx;
reg eng_act, eng_done, eng_err;
reg [1:0] op, quarter;
reg [3:0] bitn;
reg [8:0] sh, rxsh;
reg [5:0] qcnt;
reg [25:0] acq_cnt;
wire stall = (quarter == 2'h0 && op == `OP_START && !(scl_s && sda_s)) ||
             (quarter == 2'h1 && op != `OP_START && !scl_s);

always @(posedge clk_i) begin
    if (rst_i) begin
        eng_act <= 1'b0;
        eng_done <= 1'b0;
        eng_err <= 1'b0;
        op <= `OP_START;
        quarter <= 2'h0;
        bitn <= 4'h0;
        sh <= 9'h1ff;
        rxsh <= 9'h1ff;
        qcnt <= 6'h00;
        acq_cnt <= 26'h0;
        scl_oe_o <= 1'b0;
        sda_oe_o <= 1'b0;
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end else begin
        eng_done <= 1'b0;
        eng_err <= 1'b0;
        if (eng_go) begin
            eng_act <= 1'b1;
            op <= eng_op;
            quarter <= 2'h0;
            bitn <= 4'h0;
            qcnt <= 6'h00;
            acq_cnt <= 26'h0;
            sh <= eng_tx;
            if (eng_op == `OP_START) begin
                scl_oe_o <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (eng_op == `OP_STOP) begin
                sda_oe_o <= 1'b1;
            end else begin
                sda_oe_o <= ~eng_tx[8];
            end
        end else if (eng_act && stall) begin
            // A held clock or a busy bus counts toward the acquisition limit.
            acq_cnt <= acq_cnt + 26'h1;
            if (acq_cnt == ACQ_LAST[25:0]) begin
                eng_act <= 1'b0;
                eng_err <= 1'b1;
                scl_oe_o <= 1'b0;
                sda_oe_o <= 1'b0;
            end
        end else if (eng_act) begin
            acq_cnt <= 26'h0;
            if (qcnt != Q_LAST[5:0]) begin
                qcnt <= qcnt + 6'h01;
            end else begin
                qcnt <= 6'h00;
                quarter <= quarter + 2'h1;
                case (op)
                    `OP_START: begin
                        if (quarter == 2'h1) sda_oe_o <= 1'b1;
                        if (quarter == 2'h2) scl_oe_o <= 1'b1;
                        if (quarter == 2'h3) begin
                            eng_act <= 1'b0;
                            eng_done <= 1'b1;
                        end
                    end
                    `OP_STOP: begin
                        if (quarter == 2'h0) scl_oe_o <= 1'b0;
                        if (quarter == 2'h2) sda_oe_o <= 1'b0;
                        if (quarter == 2'h3) begin
                            eng_act <= 1'b0;
                            eng_done <= 1'b1;
                        end
                    end
                    default: begin
                        if (quarter == 2'h0) scl_oe_o <= 1'b0;
                        if (quarter == 2'h1) rxsh <= {rxsh[7:0], sda_s};
                        if (quarter == 2'h2) scl_oe_o <= 1'b1;
                        if (quarter == 2'h3) begin
                            if (bitn == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                eng_act <= 1'b0;
                                eng_done <= 1'b1;
                            end else begin
                                sda_oe_o <= ~sh[7];
                                sh <= {sh[7:0], 1'b1};
                                bitn <= bitn + 4'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers and command sequencer.

reg busy, timeout, overflow, loaded, pend, polling, poll_ok, fail;
reg [2:0] code;
reg [15:0] addr, cur_addr, ld_addr;
reg [7:0] byte_reg, ld_left;
reg [3:0] state;
reg [19:0] wr_cnt;
wire acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wr = acc && wb_we_i;
wire wr_cmd = wr && wb_adr_i[9:2] == `OFS_COMMAND >> 2;
wire wr_byte = wr && wb_adr_i[9:2] == `OFS_BYTE >> 2 && wb_sel_i[0];
wire start_cmd = wr_cmd && wb_sel_i[3] && wb_dat_i[`CMD_BUSY_BIT] && !busy;
wire [2:0] new_code = wb_dat_i[`CMD_CODE_HI:`CMD_CODE_LO];
wire supported = new_code == `CODE_READ || new_code == `CODE_WRITE ||
                 new_code == `CODE_RELOAD;
wire [7:0] rx = rxsh[8:1];
wire ack_seen = ~rxsh[0];
wire is_op = state >= S_START && state <= S_STOP;
reg [1:0] next_op;
reg [8:0] next_tx;
reg [3:0] next_state;

// Engine request for each sequencer state and the state that follows it.
always @* begin
    next_op = `OP_WBYTE;
    next_tx = {`DEV_WRITE, 1'b1};
    next_state = S_FINISH;
    case (state)
        S_START: begin
            next_op = `OP_START;
            next_state = S_DEVW;
        end
        S_DEVW: next_state = polling ? S_STOP : S_AHI;
        S_AHI: begin
            next_tx = {cur_addr[15:8], 1'b1};
            next_state = S_ALO;
        end
        S_ALO: begin
            next_tx = {cur_addr[7:0], 1'b1};
            next_state = (code == `CODE_WRITE) ? S_WDATA : S_RSTART;
        end
        S_WDATA: begin
            next_tx = {byte_reg, 1'b1};
            next_state = S_STOP;
        end
        S_RSTART: begin
            next_op = `OP_START;
            next_state = S_DEVR;
        end
        S_DEVR: begin
            next_tx = {`DEV_READ, 1'b1};
            next_state = S_RDATA;
        end
        S_RDATA: begin
            next_op = `OP_RBYTE;
            next_tx = 9'h1ff;
            next_state = S_STOP;
        end
        S_STOP: next_op = `OP_STOP;
        default: next_state = S_IDLE;
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
        busy <= 1'b0;
        timeout <= 1'b0;
        overflow <= 1'b0;
        loaded <= 1'b0;
        ready_o <= 1'b1;
        code <= `CODE_READ;
        addr <= `RST_ADDR;
        byte_reg <= `RST_BYTE;
        cur_addr <= 16'h0;
        ld_addr <= 16'h0;
        ld_left <= 8'h00;
        state <= S_IDLE;
        pend <= 1'b0;
        polling <= 1'b0;
        poll_ok <= 1'b0;
        fail <= 1'b0;
        wr_cnt <= 20'h0;
        eng_go <= 1'b0;
        eng_op <= `OP_START;
        eng_tx <= 9'h1ff;
        cfg_addr_o <= 16'h0;
        cfg_data_o <= 8'h00;
        cfg_we_o <= 1'b0;
    end else begin
        wb_ack_o <= acc;
        eng_go <= 1'b0;
        cfg_we_o <= 1'b0;
        case (wb_adr_i[9:2])
            `OFS_COMMAND >> 2: wb_dat_o <= {busy, code, 9'h000, overflow, timeout, loaded,
                                             addr};
            `OFS_BYTE >> 2: wb_dat_o <= {24'h0, byte_reg};
            `OFS_HW_CONFIG >> 2: wb_dat_o <= {4'h0, ready_o, 27'h0};
            default: wb_dat_o <= 32'h0;
        endcase
        // Clears come first so that a hardware set later in this block wins.
        if (wr_cmd && wb_sel_i[2] && wb_dat_i[`CMD_TIMEOUT_BIT]) timeout <= 1'b0;
        if (wr_cmd && wb_sel_i[2] && wb_dat_i[`CMD_LOADED_BIT]) loaded <= 1'b0;
        if (wr_cmd && !busy && wb_sel_i[0]) addr[7:0] <= wb_dat_i[7:0];
        if (wr_cmd && !busy && wb_sel_i[1]) addr[15:8] <= wb_dat_i[15:8];
        if (wr_byte && !busy) byte_reg <= wb_dat_i[7:0];
        if (start_cmd && !supported) begin
            timeout <= 1'b1;
        end else if (start_cmd) begin
            busy <= 1'b1;
            code <= new_code;
            polling <= 1'b0;
            fail <= 1'b0;
            state <= S_START;
            cur_addr <= (new_code == `CODE_RELOAD) ? 16'h0 : addr;
            if (wb_sel_i[0]) cur_addr[7:0] <= (new_code == `CODE_RELOAD) ? 8'h00 :
                                              wb_dat_i[7:0];
            if (wb_sel_i[1]) cur_addr[15:8] <= (new_code == `CODE_RELOAD) ? 8'h00 :
                                               wb_dat_i[15:8];
            if (new_code == `CODE_RELOAD) begin
                ready_o <= 1'b0;
                loaded <= 1'b0;
                overflow <= 1'b0;
                ld_addr <= 16'h0;
            end
        end else if (eng_err) begin
            timeout <= 1'b1;
            busy <= 1'b0;
            ready_o <= 1'b1;
            pend <= 1'b0;
            state <= S_IDLE;
        end else if (is_op) begin
            if (polling) wr_cnt <= wr_cnt + 20'h1;
            if (!pend) begin
                pend <= 1'b1;
                eng_go <= 1'b1;
                eng_op <= next_op;
                eng_tx <= next_tx;
            end else if (eng_done) begin
                pend <= 1'b0;
                state <= next_state;
                if (next_op == `OP_WBYTE && state == S_DEVW && polling) poll_ok <= ack_seen;
                else if (next_op == `OP_WBYTE && !ack_seen) begin
                    fail <= 1'b1;
                    state <= S_STOP;
                end
            end
        end else if (state == S_FINISH) begin
            state <= S_IDLE;
            busy <= 1'b0;
            if (polling) wr_cnt <= wr_cnt + 20'h1;
            if (fail) begin
                timeout <= 1'b1;
                ready_o <= 1'b1;
            end else if (code == `CODE_WRITE) begin
                // Acknowledge polling waits out the EEPROM's internal write cycle.
                if (!polling || (!poll_ok && wr_cnt < WR_LAST[19:0])) begin
                    busy <= 1'b1;
                    state <= S_START;
                    polling <= 1'b1;
                    poll_ok <= 1'b0;
                    if (!polling) wr_cnt <= 20'h0;
                end else if (!poll_ok) begin
                    timeout <= 1'b1;
                end
            end else if (code == `CODE_READ) begin
                byte_reg <= rx;
            end else begin
                busy <= 1'b1;
                state <= S_START;
                if (ld_addr == 16'h0 && rx != `SIGNATURE) begin
                    busy <= 1'b0;
                    state <= S_IDLE;
                    ready_o <= 1'b1;
                end else if ((ld_addr == 16'h1 && rx == 8'h00) ||
                             (ld_addr > 16'h1 && ld_left == 8'h01)) begin
                    busy <= 1'b0;
                    state <= S_IDLE;
                    ready_o <= 1'b1;
                    loaded <= 1'b1;
                end else if (ld_addr == `EE_ADDR_LAST) begin
                    overflow <= 1'b1;
                    busy <= 1'b0;
                    state <= S_IDLE;
                    ready_o <= 1'b1;
                end else begin
                    ld_addr <= ld_addr + 16'h1;
                    cur_addr <= ld_addr + 16'h1;
                end
                if (ld_addr == 16'h1) ld_left <= rx;
                if (ld_addr > 16'h1) begin
                    ld_left <= ld_left - 8'h01;
                    cfg_we_o <= 1'b1;
                    cfg_addr_o <= ld_addr - 16'h2;
                    cfg_data_o <= rx;
                end
            end
        end
    end
end

endmodule // eeprom_command_status

/* File: eeprom_command_status_assertions.sv */
`timescale 1ns/1ps
`include "eeprom_consts.vh"
module eeprom_command_status_assertions (
    // Clock, reset and register bus
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Link and loader
    input wire scl_o,
    input wire scl_oe_o,
    input wire sda_o,
    input wire sda_oe_o,
    input wire ready_o,
    input wire cfg_we_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire rd = wb_ack_o && !wb_we_i;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire known = wb_adr_i == `OFS_COMMAND || wb_adr_i == `OFS_BYTE || wb_adr_i == `OFS_HW_CONFIG;
    //////////////////////////////
    a_ack_single: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse after request");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_reserved_zero: assert property (
        rd && wb_adr_i == `OFS_COMMAND |-> wb_dat_o[27:19] == 9'h000)
        else $error("reserved command bits not zero");
    a_byte_upper: assert property (
        rd && wb_adr_i == `OFS_BYTE |-> wb_dat_o[31:8] == 24'h000000)
        else $error("byte register upper bits not zero");
    a_hardware_config_reg_bits: assert property (
        rd && wb_adr_i == `OFS_HW_CONFIG |-> (wb_dat_o & 32'hf7ff_ffff) == 32'h0)
        else $error("hardware config holds more than ready");
    a_unmapped_zero: assert property (rd && !known |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_reload_drops_ready: assert property (
        req && wb_we_i && wb_adr_i == `OFS_COMMAND && wb_sel_i[3]
        && wb_dat_i[31:28] == 4'hf && ready_o |-> ##[1:2] !ready_o)
        else $error("ready stayed high after reload");
    a_cfg_not_ready: assert property (cfg_we_o |-> !$past(ready_o))
        else $error("loader byte while ready");
    a_open_drain: assert property (!scl_o && !sda_o)
        else $error("link output driven high");
    a_reset_state: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !scl_oe_o && !sda_oe_o && ready_o && !cfg_we_o)
        else $error("outputs not idle after reset");
    c_reload: cover property (req && wb_we_i && wb_dat_i[31:28] == 4'hf);
    c_cfg_byte: cover property (cfg_we_o);
    c_ready_back: cover property ($rose(ready_o));
endmodule // eeprom_command_status_assertions
bind eeprom_command_status eeprom_command_status_assertions u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .ready_o(ready_o), .cfg_we_o(cfg_we_o));

/* File: eeprom_link_model.sv */
`timescale 1ns/1ps
module eeprom_link_model (
    // Resolved lines
    input wire scl_i,
    input wire sda_i,
    // Misbehaviour the bench may order
    input wire refuse_i,
    input wire stretch_i,
    // Pull-down enables
    output reg scl_oe_o,
    output reg sda_oe_o
);
    reg [7:0] mem [0:2047];
    reg [7:0] sh;
    reg [7:0] rdat;
    reg [3:0] bc;
    reg [1:0] ph;
    reg [15:0] adr;
    reg act = 1'b0;
    reg rd = 1'b0;
    initial sda_oe_o = 1'b0;
    // Holding the clock low stands for a slave that never lets the bus go.
    always @* scl_oe_o = stretch_i;
    always @(negedge sda_i) if (scl_i) begin
        act = 1'b1;
        bc = 4'h0;
        ph = 2'h0;
        rd = 1'b0;
    end
    always @(posedge sda_i) if (scl_i) act = 1'b0;
    always @(posedge scl_i) if (act) begin
        // A master that does not acknowledge a read byte ends the read, so the line is let go.
        if (bc == 4'h8 && rd && sda_i) rd = 1'b0;
        if (bc < 4'h8) sh = {sh[6:0], sda_i};
        bc = bc + 4'h1;
    end
    always @(negedge scl_i) if (act) begin
        sda_oe_o = 1'b0;
        if (bc == 4'h9) bc = 4'h0;
        if (bc == 4'h8 && !rd && !refuse_i && (sh[7:1] == 7'h50 || ph != 2'h0)) begin
            sda_oe_o = 1'b1;
            case (ph)
                2'h0: begin rd = sh[0]; rdat = mem[adr[10:0]]; end
                2'h1: adr[15:8] = sh;
                2'h2: adr[7:0] = sh;
                default: mem[adr[10:0]] = sh;
            endcase
            if (ph != 2'h3) ph = ph + 2'h1;
        end else if (rd && bc < 4'h8) sda_oe_o = !rdat[3'h7 - bc[2:0]];
    end
endmodule // eeprom_link_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "eeprom_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    logic clk, rst, cyc, stb, we, refuse, stretch, ack, scl_oe, sda_oe, ready, cfg_we;
    logic m_scl_oe, m_sda_oe;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, rdata, r;
    logic [15:0] cfg_addr, a;
    logic [7:0] cfg_data, d;
    logic [63:0] note;
    logic [23:0] cfg_note;
    logic [63:0] rq[$];
    logic [23:0] cq[$];
    logic [31:0] seed = 32'h15b4;
    int err_count = 0;
    int samples_checked = 0;
    wire scl_line = !(scl_oe | m_scl_oe);
    wire sda_line = !(sda_oe | m_sda_oe);
    eeprom_command_status #(.WR_CYCLES(2000), .ACQ_CYCLES(3000)) dut (.clk_i(clk),
        .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .scl_i(scl_line), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(),
        .sda_oe_o(sda_oe), .ready_o(ready), .cfg_addr_o(cfg_addr),
        .cfg_data_o(cfg_data), .cfg_we_o(cfg_we));
    eeprom_link_model lm (.scl_i(scl_line), .sda_i(sda_line), .refuse_i(refuse),
        .stretch_i(stretch), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
    always #25 clk = ~clk;
    //////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Ack and read data are taken at the rising edge that sees ack high; the request
    // is released by non-blocking assignment at that same edge, so it never races.
    task automatic wb(input logic w, input logic [9:0] ad, input logic [31:0] dt,
        input logic [3:0] s, input logic [31:0] m, input logic [31:0] e);
        if (!w) rq.push_back({m, e});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= dt;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdata = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [9:0] ad, input logic [31:0] dt, input logic [3:0] s);
        wb(1'b1, ad, dt, s, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [9:0] ad, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, ad, 32'h0, 4'hf, m, e);
    endtask
    task automatic poll(input logic [9:0] ad, input int b, input logic v);
        int k;
        k = 0;
        do begin
            rd(ad, 32'h0, 32'h0);
            k++;
        end while (rdata[b] !== v && k < 20000);
        if (k >= 20000) err_count++;
    endtask
    task results;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    //////////////////////////////
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            note = rq.pop_front();
            if (note[63:32] !== 32'h0) `CHK(dat_o & note[63:32], note[31:0])
        end
        if (cfg_we === 1'b1) begin
            cfg_note = cq.pop_front();
            `CHK({cfg_addr, cfg_data}, cfg_note)
        end
    end
    initial begin
        repeat (95000) @(posedge clk);
        err_count++;
        results();
    end
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 10'h000;
        sel = 4'h0;
        dat = 32'h0;
        refuse = 1'b0;
        stretch = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`OFS_COMMAND, 32'hffff_ffff, 32'h0);
        rd(`OFS_BYTE, 32'hffff_ffff, 32'h0);
        rd(`OFS_HW_CONFIG, 32'hffff_ffff, 32'h0800_0000);
        rd(10'h3f0, 32'hffff_ffff, 32'h0);
        r = rnd();
        d = r[7:0];
        a = {5'h00, r[18:8]};
        wr(`OFS_BYTE, r, 4'hf);
        rd(`OFS_BYTE, 32'hffff_ffff, {24'h0, d});
        $display("register test done");
        wr(`OFS_COMMAND, {4'hb, 12'h0, a}, 4'hf);
        poll(`OFS_COMMAND, 31, 1'b0);
        `CHK(lm.mem[a[10:0]], d)
        rd(`OFS_COMMAND, 32'h8003_ffff, {16'h0, a});
        a = a ^ 16'h0155;
        r = rnd();
        lm.mem[a[10:0]] = r[7:0];
        wr(`OFS_COMMAND, {4'h8, 12'h0, a}, 4'hf);
        wr(`OFS_BYTE, ~r, 4'hf);
        wr(`OFS_COMMAND, {4'hb, 12'h0, ~a}, 4'hf);
        poll(`OFS_COMMAND, 31, 1'b0);
        rd(`OFS_BYTE, 32'hffff_ffff, {24'h0, r[7:0]});
        rd(`OFS_COMMAND, 32'h8003_ffff, {16'h0, a});
        $display("eeprom access test done");
        for (int c = 1; c < 7; c++) begin
            if (c == 3) continue;
            wr(`OFS_COMMAND, {1'b1, c[2:0], 28'h0}, 4'h8);
            rd(`OFS_COMMAND, 32'h8002_0000, 32'h0002_0000);
            wr(`OFS_COMMAND, 32'h0, 4'h4);
            rd(`OFS_COMMAND, 32'h0002_0000, 32'h0002_0000);
            wr(`OFS_COMMAND, 32'h0002_0000, 4'h4);
            rd(`OFS_COMMAND, 32'h0002_0000, 32'h0);
        end
        $display("unsupported code test done");
        for (int f = 0; f < 2; f++) begin
            refuse <= (f == 0);
            stretch <= (f == 1);
            wr(`OFS_COMMAND, {4'hb, 12'h0, a}, 4'hf);
            poll(`OFS_COMMAND, 31, 1'b0);
            rd(`OFS_COMMAND, 32'h8002_0000, 32'h0002_0000);
            wr(`OFS_COMMAND, 32'h0002_0000, 4'h4);
        end
        refuse <= 1'b0;
        stretch <= 1'b0;
        $display("link fault test done");
        lm.mem[0] = 8'ha5;
        lm.mem[1] = 8'h01;
        lm.mem[2] = r[15:8];
        cq.push_back({16'h0, r[15:8]});
        // The second pass has a broken signature, so the loaded flag must fall.
        for (int g = 0; g < 2; g++) begin
            wr(`OFS_COMMAND, 32'hf000_0000, 4'h8);
            rd(`OFS_HW_CONFIG, 32'h0800_0000, 32'h0);
            poll(`OFS_HW_CONFIG, 27, 1'b1);
            rd(`OFS_COMMAND, 32'h0007_0000, {15'h0, g == 0, 16'h0});
            lm.mem[0] = 8'h5a;
        end
        `CHK(cq.size(), 0)
        $display("reload test done");
        results();
    end
endmodule // testbench
